// File: hw/pec_pkg.sv
// Package with constants and types for the performance event control and cycle stamp block.
package pec_pkg;
   // --------------------------------------------------------------------
   // Event-select field layout
   // --------------------------------------------------------------------
   localparam int PEC_SEL_EVT_LO_LSB = 0;
   localparam int PEC_SEL_EVT_LO_MSB = 7;
   localparam int PEC_SEL_UNIT_LSB = 8;
   localparam int PEC_SEL_UNIT_MSB = 15;
   localparam int PEC_SEL_USR_BIT = 16;
   localparam int PEC_SEL_OS_BIT = 17;
   localparam int PEC_SEL_INT_BIT = 20;
   localparam int PEC_SEL_EN_BIT = 22;
   localparam int PEC_SEL_EVT_HI_LSB = 32;
   localparam int PEC_SEL_EVT_HI_MSB = 35;
   // Writable bits: event code, unit mask, mode bits, interrupt and enable.
   localparam logic [63:0] PEC_SEL_WMASK = 64'h0000_000F_0053_FFFF;
   localparam logic [63:0] PEC_SEL_RESET = 64'h0000_0000_0000_0000;
   localparam logic [63:0] PEC_STAMP_RESET = 64'h0000_0000_0000_0000;

   // --------------------------------------------------------------------
   // Model-register selectors and feature-query bits
   // --------------------------------------------------------------------
   localparam logic [7:0] PEC_MREG_STAMP = 8'h10;
   localparam logic [7:0] PEC_MREG_SEL_BASE = 8'h20;
   localparam logic [7:0] PEC_MREG_CTR_BASE = 8'h30;
   localparam int PEC_FQ_STAMP_BIT = 4;
   localparam int PEC_FQ_SER_READ_BIT = 27;
   localparam logic [1:0] PEC_CPL_KERNEL = 2'h0;

   // Operation requested by the core pipeline.
   typedef enum logic [2:0] {
      PEC_OP_NONE,
      PEC_OP_MREG_READ,
      PEC_OP_MREG_WRITE,
      PEC_OP_PLAIN_READ,
      PEC_OP_SER_READ
   } pec_op_e;

   // Sequencer states.
   typedef enum logic [1:0] {
      PEC_ST_IDLE,
      PEC_ST_DRAIN,
      PEC_ST_DONE
   } pec_state_e;
endpackage : pec_pkg

// File: hw/pec_counter.sv
// One cache-level event counter with privilege gating and overflow detection.
`timescale 1ns/1ps
`default_nettype none
module pec_counter
   import pec_pkg::*;
#(
   parameter int CTR_W = 48
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Control
   input wire logic [63:0] select_i,
   input wire logic [1:0] current_privilege_level_i,
   input wire logic event_i,
   input wire logic load_i,
   input wire logic [CTR_W-1:0] load_val_i,
   // Status
   output logic [CTR_W-1:0] count_o,
   output logic overflow_o
);
   logic [CTR_W-1:0] count_reg, count_next;
   logic ovf_reg, ovf_next;
   logic lvl_ok;
   logic [CTR_W:0] sum;

   always_comb begin
      if (current_privilege_level_i == PEC_CPL_KERNEL) begin
         lvl_ok = select_i[PEC_SEL_OS_BIT];
      end else begin
         lvl_ok = select_i[PEC_SEL_USR_BIT];
      end
   end

   always_comb begin
      sum = {1'b0, count_reg} + {{CTR_W{1'b0}}, 1'b1};
      count_next = count_reg;
      ovf_next = 1'b0;
      if (load_i) begin
         count_next = load_val_i;
      end else if (select_i[PEC_SEL_EN_BIT] && lvl_ok && event_i) begin
         count_next = sum[CTR_W-1:0];
         ovf_next = sum[CTR_W];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         count_reg <= '0;
         ovf_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         ovf_reg <= ovf_next;
      end
   end

   assign count_o = count_reg;
   assign overflow_o = ovf_reg;

   property p_no_count_gated;
      @(posedge clk_sys_i) disable iff (rst_i)
      (!load_i && !lvl_ok) |=> (count_reg == $past(count_reg));
   endproperty
   a_no_count_gated: assert property (p_no_count_gated) else $error("count moved while gated");

   property p_ovf_wrap;
      @(posedge clk_sys_i) disable iff (rst_i)
      ovf_reg |-> (count_reg == '0);
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow without wrap");
endmodule : pec_counter
`default_nettype wire

// File: hw/pec_top.sv
// Cache-level event-select registers, counters and cycle stamp counter.
// Summary of operation
// - Each select register is 64 bits; event code bits 35:32 and 7:0.
// - Each counter has enable bit 22, interrupt enable 20, unit mask 15:8.
// - Select registers accessible only at level 0, otherwise protection fault.
// - Feature flags report core, bridge and cache counter support.
// - Counting starts and stops when the enabling write completes.
// - Overflow interrupt raised only while interrupt enable is set.
// - Cycle stamp clears to zero on reset.
// - Cycle stamp advances every baseline clock after reset.
// - Each stamp read returns a strictly larger value until the stamp wraps or is written.
// - Cycle stamp wraps to zero after all ones.
// - Stamp reads give upper 32 bits upper, lower 32 bits lower.
// - Stamp reads work at any level unless disabled.
// - Disable set and level above 0 faults stamp reads.
// - Cycle stamp readable and writable through model-register access.
// - Feature query reports stamp support bit 4, serializing read bit 27.
// - Plain read is not serializing; serializing read waits for drain.
// - Constant-rate flag set only when stamp rate is fixed.
// - Mode bits select counting levels: none, user, system or all.
`timescale 1ns/1ps
`default_nettype none
module pec_top
   import pec_pkg::*;
#(
   parameter int NUM_CTR = 4,
   parameter int CTR_W = 48,
   parameter bit HAS_CORE_EXT = 1'b1,
   parameter bit HAS_BRIDGE_EXT = 1'b1,
   parameter bit CONSTANT_RATE = 1'b1
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // Core request
   input wire logic req_i,
   input wire logic [2:0] op_i,
   input wire logic [7:0] mreg_sel_i,
   input wire logic [31:0] upper_wdata_i,
   input wire logic [31:0] lower_wdata_i,
   input wire logic [1:0] current_privilege_level_i,
   input wire logic stamp_disable_bit_i,
   input wire logic pipe_drained_i,
   // Events
   input wire logic [NUM_CTR-1:0] event_i,
   // Answer
   output logic done_o,
   output logic protection_fault_o,
   output logic [31:0] upper_result_reg_o,
   output logic [31:0] lower_result_reg_o,
   // Interrupt and feature flags
   output logic [NUM_CTR-1:0] overflow_irq_o,
   output logic ext_core_counters_flag_o,
   output logic ext_bridge_counters_flag_o,
   output logic ext_cache_counters_flag_o,
   output logic constant_rate_flag_o,
   output logic stamp_support_o,
   output logic ser_read_support_o
);
   // --------------------------------------------------------------------
   // State
   // --------------------------------------------------------------------
   logic [63:0] sel_reg [NUM_CTR];
   logic [63:0] sel_next [NUM_CTR];
   logic [63:0] stamp_reg, stamp_next;
   pec_state_e state_reg, state_next;
   logic done_reg, done_next;
   logic fault_reg, fault_next;
   logic [31:0] up_reg, up_next, lo_reg, lo_next;
   logic [NUM_CTR-1:0] irq_reg, irq_next;
   logic [NUM_CTR-1:0] ovf;
   logic [NUM_CTR-1:0] ctr_load;
   logic [CTR_W-1:0] ctr_val [NUM_CTR];
   logic [63:0] wdata;
   logic flags_reg;
   pec_op_e op;

   assign op = pec_op_e'(op_i);
   assign wdata = {upper_wdata_i, lower_wdata_i};

   // Selector decode helper.
   function automatic logic in_bank(input logic [7:0] sel, input logic [7:0] base);
      in_bank = (sel >= base) && (sel < base + 8'(NUM_CTR));
   endfunction

   // --------------------------------------------------------------------
   // Counters
   // --------------------------------------------------------------------
   for (genvar g = 0; g < NUM_CTR; g++) begin : g_ctr
      pec_counter #(
         .CTR_W(CTR_W)
      ) u_ctr (
         .clk_sys_i(clk_sys_i),
         .rst_i(rst_i),
         .select_i(sel_reg[g]),
         .current_privilege_level_i(current_privilege_level_i),
         .event_i(event_i[g]),
         .load_i(ctr_load[g]),
         .load_val_i(wdata[CTR_W-1:0]),
         .count_o(ctr_val[g]),
         .overflow_o(ovf[g])
      );
   end

   // --------------------------------------------------------------------
   // Request sequencer
   // --------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      done_next = 1'b0;
      fault_next = 1'b0;
      up_next = up_reg;
      lo_next = lo_reg;
      ctr_load = '0;
      stamp_next = stamp_reg + 64'h0000_0000_0000_0001;
      for (int i = 0; i < NUM_CTR; i++) begin
         sel_next[i] = sel_reg[i];
      end
      case (state_reg)
         PEC_ST_IDLE: begin
            if (req_i) begin
               case (op)
                  PEC_OP_MREG_READ, PEC_OP_MREG_WRITE: begin
                     if (current_privilege_level_i != PEC_CPL_KERNEL) begin
                        fault_next = 1'b1;
                     end else if (op == PEC_OP_MREG_WRITE) begin
                        if (mreg_sel_i == PEC_MREG_STAMP) begin
                           stamp_next = wdata;
                        end
                        for (int i = 0; i < NUM_CTR; i++) begin
                           if (mreg_sel_i == PEC_MREG_SEL_BASE + 8'(i)) begin
                              sel_next[i] = wdata & PEC_SEL_WMASK;
                           end
                           if (mreg_sel_i == PEC_MREG_CTR_BASE + 8'(i)) begin
                              ctr_load[i] = 1'b1;
                           end
                        end
                     end else begin
                        up_next = 32'h0000_0000;
                        lo_next = 32'h0000_0000;
                        if (mreg_sel_i == PEC_MREG_STAMP) begin
                           {up_next, lo_next} = stamp_reg;
                        end
                        for (int i = 0; i < NUM_CTR; i++) begin
                           if (mreg_sel_i == PEC_MREG_SEL_BASE + 8'(i)) begin
                              {up_next, lo_next} = sel_reg[i];
                           end
                           if (mreg_sel_i == PEC_MREG_CTR_BASE + 8'(i)) begin
                              {up_next, lo_next} = 64'(ctr_val[i]);
                           end
                        end
                     end
                     done_next = 1'b1;
                     state_next = PEC_ST_DONE;
                  end
                  PEC_OP_PLAIN_READ, PEC_OP_SER_READ: begin
                     if (stamp_disable_bit_i &&
                         current_privilege_level_i != PEC_CPL_KERNEL) begin
                        fault_next = 1'b1;
                        done_next = 1'b1;
                        state_next = PEC_ST_DONE;
                     end else if (op == PEC_OP_SER_READ && !pipe_drained_i) begin
                        state_next = PEC_ST_DRAIN;
                     end else begin
                        {up_next, lo_next} = stamp_reg;
                        done_next = 1'b1;
                        state_next = PEC_ST_DONE;
                     end
                  end
                  default: begin
                     state_next = PEC_ST_IDLE;
                  end
               endcase
            end
         end
         PEC_ST_DRAIN: begin
            if (pipe_drained_i) begin
               {up_next, lo_next} = stamp_reg;
               done_next = 1'b1;
               state_next = PEC_ST_DONE;
            end
         end
         PEC_ST_DONE: begin
            state_next = PEC_ST_IDLE;
         end
         default: begin
            state_next = PEC_ST_IDLE;
         end
      endcase
   end

   always_comb begin
      for (int i = 0; i < NUM_CTR; i++) begin
         irq_next[i] = ovf[i] && sel_reg[i][PEC_SEL_INT_BIT];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         stamp_reg <= PEC_STAMP_RESET;
         state_reg <= PEC_ST_IDLE;
         done_reg <= 1'b0;
         fault_reg <= 1'b0;
         up_reg <= 32'h0000_0000;
         lo_reg <= 32'h0000_0000;
         irq_reg <= '0;
         flags_reg <= 1'b0;
         for (int i = 0; i < NUM_CTR; i++) begin
            sel_reg[i] <= PEC_SEL_RESET;
         end
      end else begin
         stamp_reg <= stamp_next;
         state_reg <= state_next;
         done_reg <= done_next;
         fault_reg <= fault_next;
         up_reg <= up_next;
         lo_reg <= lo_next;
         irq_reg <= irq_next;
         flags_reg <= 1'b1;
         for (int i = 0; i < NUM_CTR; i++) begin
            sel_reg[i] <= sel_next[i];
         end
      end
   end

   // --------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------
   assign done_o = done_reg;
   assign protection_fault_o = fault_reg;
   assign upper_result_reg_o = up_reg;
   assign lower_result_reg_o = lo_reg;
   assign overflow_irq_o = irq_reg;
   assign ext_core_counters_flag_o = flags_reg & HAS_CORE_EXT;
   assign ext_bridge_counters_flag_o = flags_reg & HAS_BRIDGE_EXT;
   assign ext_cache_counters_flag_o = flags_reg;
   assign constant_rate_flag_o = flags_reg & CONSTANT_RATE;
   assign stamp_support_o = flags_reg;
   assign ser_read_support_o = flags_reg;

   // --------------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------------
   sequence s_user_stamp_read;
      req_i && state_reg == PEC_ST_IDLE && stamp_disable_bit_i &&
      current_privilege_level_i != PEC_CPL_KERNEL &&
      (op == PEC_OP_PLAIN_READ || op == PEC_OP_SER_READ);
   endsequence

   property p_stamp_fault;
      @(posedge clk_sys_i) disable iff (rst_i)
      s_user_stamp_read |=> (protection_fault_o && done_o);
   endproperty
   a_stamp_fault: assert property (p_stamp_fault) else $error("no fault on stamp read");

   property p_mreg_fault;
      @(posedge clk_sys_i) disable iff (rst_i)
      (req_i && state_reg == PEC_ST_IDLE && current_privilege_level_i != PEC_CPL_KERNEL &&
       (op == PEC_OP_MREG_READ || op == PEC_OP_MREG_WRITE)) |=> protection_fault_o;
   endproperty
   a_mreg_fault: assert property (p_mreg_fault) else $error("no fault on user access");

   property p_stamp_inc;
      @(posedge clk_sys_i) disable iff (rst_i)
      !(req_i && state_reg == PEC_ST_IDLE && op == PEC_OP_MREG_WRITE &&
        mreg_sel_i == PEC_MREG_STAMP && current_privilege_level_i == PEC_CPL_KERNEL)
      |=> stamp_reg == $past(stamp_reg) + 64'h0000_0000_0000_0001;
   endproperty
   a_stamp_inc: assert property (p_stamp_inc) else $error("stamp did not advance");

   property p_stamp_reset;
      @(posedge clk_sys_i) rst_i |=> stamp_reg == 64'h0000_0000_0000_0000;
   endproperty
   a_stamp_reset: assert property (p_stamp_reset) else $error("stamp not cleared");

   property p_plain_read;
      @(posedge clk_sys_i) disable iff (rst_i)
      (req_i && state_reg == PEC_ST_IDLE && op == PEC_OP_PLAIN_READ && !stamp_disable_bit_i)
      |=> ({upper_result_reg_o, lower_result_reg_o} == $past(stamp_reg) && done_o);
   endproperty
   a_plain_read: assert property (p_plain_read) else $error("stamp halves wrong");

   property p_irq_gate;
      @(posedge clk_sys_i) disable iff (rst_i)
      overflow_irq_o[0] |-> $past(ovf[0]) && $past(sel_reg[0][PEC_SEL_INT_BIT]);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("interrupt without enable");

   property p_ser_wait;
      @(posedge clk_sys_i) disable iff (rst_i)
      (state_reg == PEC_ST_DRAIN && !pipe_drained_i) |=> !done_o;
   endproperty
   a_ser_wait: assert property (p_ser_wait) else $error("serializing read ran early");

   property p_sel_reserved;
      @(posedge clk_sys_i) disable iff (rst_i)
      (sel_reg[0] & ~PEC_SEL_WMASK) == 64'h0000_0000_0000_0000;
   endproperty
   a_sel_reserved: assert property (p_sel_reserved) else $error("reserved bits set");
endmodule : pec_top
`default_nettype wire

// File: tb/pec_top_tb.sv
// Self-checking testbench for the performance event control and cycle stamp block.
`timescale 1ns/1ps
`default_nettype none
module pec_top_tb
   import pec_pkg::*;
;
   // ---------------------------------------------------------------------
   // Stimulus and observed signals
   // ---------------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic req_i = 1'b0;
   logic [2:0] op_i = 3'h0;
   logic [7:0] mreg_sel_i = 8'h00;
   logic [31:0] upper_wdata_i = 32'h0000_0000;
   logic [31:0] lower_wdata_i = 32'h0000_0000;
   logic [1:0] current_privilege_level_i = 2'h0;
   logic stamp_disable_bit_i = 1'b0;
   logic pipe_drained_i = 1'b1;
   logic [3:0] event_i = 4'h0;
   logic done_o;
   logic protection_fault_o;
   logic [31:0] upper_result_reg_o;
   logic [31:0] lower_result_reg_o;
   logic [3:0] overflow_irq_o;
   logic [5:0] flags;
   logic [63:0] rd_val;
   logic [63:0] prev;
   logic rd_fault;
   int mismatches = 0;
   int samples_checked = 0;
   int cycles = 0;
   int rd_wait;
   int irq_seen [4] = '{0, 0, 0, 0};

   pec_top #(.NUM_CTR(4), .CTR_W(48)) uut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i), .op_i(op_i),
      .mreg_sel_i(mreg_sel_i), .upper_wdata_i(upper_wdata_i), .lower_wdata_i(lower_wdata_i),
      .current_privilege_level_i(current_privilege_level_i),
      .stamp_disable_bit_i(stamp_disable_bit_i), .pipe_drained_i(pipe_drained_i),
      .event_i(event_i), .done_o(done_o), .protection_fault_o(protection_fault_o),
      .upper_result_reg_o(upper_result_reg_o), .lower_result_reg_o(lower_result_reg_o),
      .overflow_irq_o(overflow_irq_o), .ext_core_counters_flag_o(flags[0]),
      .ext_bridge_counters_flag_o(flags[1]), .ext_cache_counters_flag_o(flags[2]),
      .constant_rate_flag_o(flags[3]), .stamp_support_o(flags[4]),
      .ser_read_support_o(flags[5])
   );

   always #4 clk_sys_i = ~clk_sys_i;

   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         final_report();
      end
   end

   always @(negedge clk_sys_i) begin
      for (int i = 0; i < 4; i++) begin
         if (overflow_irq_o[i] === 1'b1) irq_seen[i]++;
      end
   end

   // ---------------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------------
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Issues one request at a falling edge and waits for its answer.
   task automatic access(input logic [2:0] op, input logic [7:0] sel, input logic [63:0] wd);
      op_i = op;
      mreg_sel_i = sel;
      {upper_wdata_i, lower_wdata_i} = wd;
      req_i = 1'b1;
      @(negedge clk_sys_i);
      req_i = 1'b0;
      rd_wait = 0;
      while (done_o !== 1'b1 && rd_wait < 40) begin
         @(negedge clk_sys_i);
         rd_wait++;
      end
      if (rd_wait >= 40) check("done", 1'b0, 1'b1);
      rd_fault = protection_fault_o;
      rd_val = {upper_result_reg_o, lower_result_reg_o};
      @(negedge clk_sys_i);
   endtask

   // Drives events on all counters for a number of edges at one level.
   task automatic burst(input int n, input logic [1:0] lvl);
      current_privilege_level_i = lvl;
      event_i = 4'hF;
      repeat (n) @(negedge clk_sys_i);
      event_i = 4'h0;
      current_privilege_level_i = 2'h0;
      repeat (3) @(negedge clk_sys_i);
   endtask

   // ---------------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------------
   task automatic t_reset;
      check("flags in reset", 64'(flags), 64'h0);
      rst_i = 1'b0;
      @(negedge clk_sys_i);
      check("feature flags", 64'(flags), 64'h3F);
      access(PEC_OP_PLAIN_READ, 8'h00, 64'h0);
      check("stamp after reset", 64'(rd_val < 64'h8), 64'h1);
   endtask

   task automatic t_stamp;
      access(PEC_OP_MREG_WRITE, PEC_MREG_STAMP, 64'hFFFF_FFFF_FFFF_FFF0);
      access(PEC_OP_MREG_READ, PEC_MREG_STAMP, 64'h0);
      check("stamp written", 64'(rd_val[63:8]), 64'h00FF_FFFF_FFFF_FFFF);
      prev = rd_val;
      access(PEC_OP_PLAIN_READ, 8'h00, 64'h0);
      check("stamp step", rd_val, prev + 64'h2);
      prev = rd_val;
      repeat (20) @(negedge clk_sys_i);
      access(PEC_OP_PLAIN_READ, 8'h00, 64'h0);
      check("stamp wrap", rd_val, prev + 64'd22);
   endtask

   task automatic t_serial;
      int early;
      pipe_drained_i = 1'b0;
      prev = rd_val;
      access(PEC_OP_PLAIN_READ, 8'h00, 64'h0);
      check("plain read no wait", 64'(rd_wait <= 1), 64'h1);
      prev = rd_val;
      op_i = PEC_OP_SER_READ;
      req_i = 1'b1;
      @(negedge clk_sys_i);
      req_i = 1'b0;
      early = 0;
      repeat (6) begin
         @(negedge clk_sys_i);
         if (done_o !== 1'b0) early++;
      end
      check("serial read early", 64'(early), 64'h0);
      pipe_drained_i = 1'b1;
      rd_wait = 0;
      while (done_o !== 1'b1 && rd_wait < 3) begin
         @(negedge clk_sys_i);
         rd_wait++;
      end
      check("serial read done", 64'(done_o), 64'h1);
      rd_val = {upper_result_reg_o, lower_result_reg_o};
      check("serial read larger", 64'(rd_val > prev), 64'h1);
      @(negedge clk_sys_i);
   endtask

   task automatic t_protect;
      for (int k = 0; k < 8; k++) begin
         current_privilege_level_i = k[0] ? 2'h3 : 2'h0;
         stamp_disable_bit_i = k[1];
         access(k[2] ? PEC_OP_SER_READ : PEC_OP_PLAIN_READ, 8'h00, 64'h0);
         check("stamp read fault", 64'(rd_fault), 64'(k[0] && k[1]));
      end
      stamp_disable_bit_i = 1'b0;
      current_privilege_level_i = 2'h2;
      access(PEC_OP_MREG_READ, PEC_MREG_SEL_BASE + 8'h1, 64'h0);
      check("select read fault", 64'(rd_fault), 64'h1);
      access(PEC_OP_MREG_WRITE, PEC_MREG_SEL_BASE + 8'h1, 64'hFFFF_FFFF_FFFF_FFFF);
      check("select write fault", 64'(rd_fault), 64'h1);
      current_privilege_level_i = 2'h0;
      access(PEC_OP_MREG_READ, PEC_MREG_SEL_BASE + 8'h1, 64'h0);
      check("select after fault", rd_val, PEC_SEL_RESET);
      check("kernel access ok", 64'(rd_fault), 64'h0);
   endtask

   task automatic t_select;
      for (int n = 0; n < 4; n++) begin
         access(PEC_OP_MREG_READ, PEC_MREG_SEL_BASE + 8'(n), 64'h0);
         check("select reset", rd_val, PEC_SEL_RESET);
         access(PEC_OP_MREG_WRITE, PEC_MREG_SEL_BASE + 8'(n), 64'hFFFF_FFFF_FFFF_FFFF);
         access(PEC_OP_MREG_READ, PEC_MREG_SEL_BASE + 8'(n), 64'h0);
         check("select fields", rd_val, PEC_SEL_WMASK);
         access(PEC_OP_MREG_WRITE, PEC_MREG_SEL_BASE + 8'(n), 64'h0);
      end
      access(PEC_OP_MREG_READ, 8'h5A, 64'h0);
      check("unmapped read", rd_val, 64'h0);
   endtask

   task automatic t_count;
      logic [63:0] exp;
      exp = 64'h0;
      access(PEC_OP_MREG_WRITE, PEC_MREG_CTR_BASE + 8'h1, 64'h0);
      for (int m = 0; m < 5; m++) begin
         access(PEC_OP_MREG_WRITE, PEC_MREG_SEL_BASE + 8'h1,
                {32'h0000_0003, 9'h000, m < 4, 4'h0, m[1] || m == 4, m[0] || m == 4, 16'h5A12});
         burst(5, 2'h0);
         burst(7, 2'h3);
         if (m < 4) exp = exp + (m[1] ? 64'd5 : 64'd0) + (m[0] ? 64'd7 : 64'd0);
         access(PEC_OP_MREG_READ, PEC_MREG_CTR_BASE + 8'h1, 64'h0);
         check("counter modes", rd_val, exp);
      end
   endtask

   task automatic t_overflow;
      for (int ie = 0; ie < 2; ie++) begin
         access(PEC_OP_MREG_WRITE, PEC_MREG_CTR_BASE + 8'h2, 64'h0000_FFFF_FFFF_FFFD);
         access(PEC_OP_MREG_WRITE, PEC_MREG_SEL_BASE + 8'h2,
                {41'h0, 1'b1, 1'b0, ie[0], 20'h2_0000});
         irq_seen[2] = 0;
         burst(6, 2'h0);
         repeat (5) @(negedge clk_sys_i);
         check("overflow requests", 64'(irq_seen[2]), 64'(ie));
         access(PEC_OP_MREG_READ, PEC_MREG_CTR_BASE + 8'h2, 64'h0);
         check("counter after wrap", rd_val, 64'h3);
      end
      access(PEC_OP_MREG_WRITE, PEC_MREG_SEL_BASE + 8'h2, 64'h0);
   endtask

   initial begin
      repeat (10) @(negedge clk_sys_i);
      t_reset();
      t_stamp();
      t_serial();
      t_protect();
      t_select();
      t_count();
      t_overflow();
      final_report();
   end
endmodule // pec_top_tb
`default_nettype wire
